/* rtl/dtit_pkg.sv */
// constants and carriers for the endpoint translation-cache invalidation tracker
package dtit_pkg;
  localparam int NUM_TAGS = 32;
  localparam int TAG_W = 5;
  localparam int SID_W = 16;
  localparam int PASID_W = 20;
  localparam int TALLY_W = 4;
  localparam int TIMER_W = 25;
  localparam int CLK_MHZ = 200;
  // read completion time-outs top out near 50 ms, so double that
  localparam int TIMEOUT_MS = 100;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_MHZ * 1000;
  localparam logic [TALLY_W-1:0] TALLY_RST = 4'h0;
  localparam logic [TALLY_W-1:0] TALLY_STEP = 4'h1;
  localparam logic [TALLY_W-1:0] COUNT_ZERO_MEANS = 4'h8;
  localparam logic [TIMER_W-1:0] TIMER_RST = 25'h0;
  localparam logic [TIMER_W-1:0] TIMER_STEP = 25'h1;
  localparam logic [SID_W-1:0] OWNER_RST = 16'h0;

  typedef enum logic {
    MSG_IDLE = 1'b0,
    MSG_SEND = 1'b1
  } dtit_msg_state_t;

  typedef struct packed {
    logic [SID_W-1:0]   endpoint_id;
    logic [63:12]       addr;
    logic               size;
    logic               global_inv;
    logic               pasid_valid;
    logic [PASID_W-1:0] pasid;
  } dtit_inv_req_t;

  typedef struct packed {
    logic [SID_W-1:0]   endpoint_id;
    logic [TAG_W-1:0]   invalidation_tag;
    logic [63:12]       addr;
    logic               size;
    logic               global_inv;
    logic               pasid_prefix;
    logic [PASID_W-1:0] pasid;
  } dtit_inv_msg_t;

  typedef struct packed {
    logic [SID_W-1:0]    source_id;
    logic [NUM_TAGS-1:0] tag_vector;
    logic [2:0]          completion_count;
  } dtit_inv_cpl_t;
endpackage

/* rtl/dtit_tag_alloc.sv */
// lowest free tag finder
`timescale 1ns/1ps
module dtit_tag_alloc #(
  parameter int NUM_TAGS = dtit_pkg::NUM_TAGS,
  parameter int TAG_W    = dtit_pkg::TAG_W
) (
  input  wire logic [NUM_TAGS-1:0] busy_vec_in,
  output logic                     any_free_out,
  output logic [TAG_W-1:0]         free_tag_out
);
  // scan from the top so the lowest free index is left standing
  always_comb begin
    any_free_out = 1'b0;
    free_tag_out = '0;
    for (int i = NUM_TAGS - 1; i >= 0; i--) begin
      if (!busy_vec_in[i]) begin
        any_free_out = 1'b1;
        free_tag_out = TAG_W'(i);
      end
    end
  end
endmodule

/* rtl/dtit_tag_entry.sv */
// per-tag owner, completion tally and completion timer
`timescale 1ns/1ps
module dtit_tag_entry #(
  parameter int TIMEOUT_CYCLES = dtit_pkg::TIMEOUT_CYCLES
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          alloc_in,
  input  wire logic [dtit_pkg::SID_W-1:0]    owner_in,
  input  wire logic                          hit_in,
  input  wire logic [dtit_pkg::TALLY_W-1:0]  expect_in,
  output logic                               busy_out,
  output logic [dtit_pkg::SID_W-1:0]         owner_out,
  output logic                               done_out,
  output logic                               expired_out
);
  localparam logic [dtit_pkg::TIMER_W-1:0] TIMER_LAST =
    dtit_pkg::TIMER_W'(TIMEOUT_CYCLES - 1);

  logic                          busy_q,  busy_d;
  logic [dtit_pkg::SID_W-1:0]    owner_q, owner_d;
  logic [dtit_pkg::TALLY_W-1:0]  tally_q, tally_d;
  logic [dtit_pkg::TIMER_W-1:0]  timer_q, timer_d;

  always_comb begin
    busy_d      = busy_q;
    owner_d     = owner_q;
    tally_d     = tally_q;
    timer_d     = timer_q;
    done_out    = 1'b0;
    expired_out = 1'b0;
    if (alloc_in) begin
      busy_d  = 1'b1;
      owner_d = owner_in;
      tally_d = dtit_pkg::TALLY_RST;
      timer_d = dtit_pkg::TIMER_RST;
    end else if (busy_q) begin
      timer_d = timer_q + dtit_pkg::TIMER_STEP;
      if (hit_in) begin
        tally_d = tally_q + dtit_pkg::TALLY_STEP;
        done_out = (tally_d == expect_in);
      end
      // a last response in the expiry cycle still counts as completion
      expired_out = !done_out && (timer_q == TIMER_LAST);
      if (done_out || expired_out) begin
        busy_d  = 1'b0;
        tally_d = dtit_pkg::TALLY_RST;
        timer_d = dtit_pkg::TIMER_RST;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q  <= 1'b0;
      owner_q <= dtit_pkg::OWNER_RST;
      tally_q <= dtit_pkg::TALLY_RST;
      timer_q <= dtit_pkg::TIMER_RST;
    end else begin
      busy_q  <= busy_d;
      owner_q <= owner_d;
      tally_q <= tally_d;
      timer_q <= timer_d;
    end
  end

  assign busy_out  = busy_q;
  assign owner_out = owner_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  tally_step_a: assert property (
    (busy_q && !alloc_in && hit_in && !done_out && !expired_out)
      |=> tally_q == $past(tally_q) + dtit_pkg::TALLY_STEP && busy_q)
    else $error("tally did not step on a response");
  free_clear_a: assert property (
    (busy_q && !alloc_in && (done_out || expired_out))
      |=> !busy_q && tally_q == dtit_pkg::TALLY_RST && timer_q == dtit_pkg::TIMER_RST)
    else $error("freed tag kept its timer or tally");
  expiry_time_a: assert property (
    (busy_q && !alloc_in && timer_q == TIMER_LAST && !hit_in) |-> expired_out)
    else $error("timer reached its limit without expiry");
endmodule

/* rtl/dtit_tracker.sv */
// endpoint translation-cache invalidation tracker top
`timescale 1ns/1ps
module dtit_tracker #(
  parameter int NUM_TAGS       = dtit_pkg::NUM_TAGS,
  parameter int TIMEOUT_CYCLES = dtit_pkg::TIMEOUT_CYCLES
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    resetn_in,
  input  wire logic                    req_valid_in,
  output logic                         req_ready_out,
  input  wire dtit_pkg::dtit_inv_req_t req_in,
  output logic                         msg_valid_out,
  input  wire logic                    msg_ready_in,
  output dtit_pkg::dtit_inv_msg_t      msg_out,
  input  wire logic                    cpl_valid_in,
  output logic                         cpl_ready_out,
  input  wire dtit_pkg::dtit_inv_cpl_t cpl_in,
  input  wire logic                    fault_event_enable_in,
  input  wire logic                    completion_error_clear_in,
  input  wire logic                    completion_timeout_clear_in,
  output logic                         completion_error_flag_out,
  output logic                         completion_timeout_flag_out,
  output logic                         fault_event_out,
  output logic [NUM_TAGS-1:0]          tags_busy_out
);
  // reset release synchroniser
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  logic [NUM_TAGS-1:0]                busy_vec;
  logic [NUM_TAGS-1:0]                done_vec;
  logic [NUM_TAGS-1:0]                expired_vec;
  logic [NUM_TAGS-1:0]                alloc_vec;
  logic [NUM_TAGS-1:0]                owner_ok_vec;
  logic [NUM_TAGS-1:0]                hit_vec;
  logic [dtit_pkg::SID_W-1:0]         owner_arr [NUM_TAGS];
  logic                               any_free;
  logic [dtit_pkg::TAG_W-1:0]         free_tag;
  logic                               req_fire;
  logic                               cpl_fire;
  logic                               cpl_bad;
  logic [dtit_pkg::TALLY_W-1:0]       expect_cnt;
  localparam logic [dtit_pkg::TIMER_W-1:0] AGE_LAST =
    dtit_pkg::TIMER_W'(TIMEOUT_CYCLES - 1);

  dtit_tag_alloc #(
    .NUM_TAGS (NUM_TAGS),
    .TAG_W    (dtit_pkg::TAG_W)
  ) u_alloc (
    .busy_vec_in  (busy_vec),
    .any_free_out (any_free),
    .free_tag_out (free_tag)
  );

  // outgoing message register; one message in flight toward the link
  dtit_pkg::dtit_msg_state_t msg_state_q, msg_state_d;
  dtit_pkg::dtit_inv_msg_t   msg_q,       msg_d;

  // no free tag keeps the queue stalled rather than dropping the request
  assign req_ready_out = any_free && (msg_state_q == dtit_pkg::MSG_IDLE || msg_ready_in);
  assign req_fire      = req_valid_in && req_ready_out;

  always_comb begin
    msg_state_d = msg_state_q;
    msg_d       = msg_q;
    if (msg_state_q == dtit_pkg::MSG_SEND && msg_ready_in) begin
      msg_state_d = dtit_pkg::MSG_IDLE;
    end
    if (req_fire) begin
      msg_state_d                = dtit_pkg::MSG_SEND;
      msg_d.endpoint_id          = req_in.endpoint_id;
      msg_d.invalidation_tag     = free_tag;
      msg_d.addr                 = req_in.addr;
      msg_d.size                 = req_in.size;
      msg_d.global_inv           = req_in.global_inv;
      msg_d.pasid_prefix         = req_in.pasid_valid;
      msg_d.pasid                = req_in.pasid_valid ? req_in.pasid : '0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      msg_state_q <= dtit_pkg::MSG_IDLE;
      msg_q       <= '0;
    end else begin
      msg_state_q <= msg_state_d;
      msg_q       <= msg_d;
    end
  end

  assign msg_valid_out = (msg_state_q == dtit_pkg::MSG_SEND);
  assign msg_out       = msg_q;

  // completion check: any bad tag drops the whole message
  assign cpl_ready_out = 1'b1;
  assign cpl_fire      = cpl_valid_in;
  assign expect_cnt    = (cpl_in.completion_count == 3'h0) ? dtit_pkg::COUNT_ZERO_MEANS
                         : {1'b0, cpl_in.completion_count};
  assign cpl_bad       = |(cpl_in.tag_vector & ~(busy_vec & owner_ok_vec));

  genvar g;
  generate
    for (g = 0; g < NUM_TAGS; g++) begin : g_tag
      // shadow age and response count, kept apart from the entries on purpose
      logic [dtit_pkg::TIMER_W-1:0] age_q,  age_d;
      logic [dtit_pkg::TALLY_W-1:0] hits_q, hits_d;
      assign owner_ok_vec[g] = (owner_arr[g] == cpl_in.source_id);
      assign alloc_vec[g]    = req_fire && (free_tag == dtit_pkg::TAG_W'(g));
      assign hit_vec[g]      = cpl_fire && !cpl_bad && cpl_in.tag_vector[g];
      dtit_tag_entry #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
      ) u_entry (
        .clk_in      (ref_clk_in),
        .rst_n_in    (rst_n_q),
        .alloc_in    (alloc_vec[g]),
        .owner_in    (req_in.endpoint_id),
        .hit_in      (hit_vec[g]),
        .expect_in   (expect_cnt),
        .busy_out    (busy_vec[g]),
        .owner_out   (owner_arr[g]),
        .done_out    (done_vec[g]),
        .expired_out (expired_vec[g])
      );

      always_comb begin
        age_d  = dtit_pkg::TIMER_RST;
        hits_d = dtit_pkg::TALLY_RST;
        if (busy_vec[g]) begin
          age_d  = age_q + dtit_pkg::TIMER_STEP;
          hits_d = hit_vec[g] ? hits_q + dtit_pkg::TALLY_STEP : hits_q;
        end
      end

      always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
          age_q  <= dtit_pkg::TIMER_RST;
          hits_q <= dtit_pkg::TALLY_RST;
        end else begin
          age_q  <= age_d;
          hits_q <= hits_d;
        end
      end

      age_bound_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        busy_vec[g] |-> age_q <= AGE_LAST)
        else $error("tag stayed busy past its time-out");
      age_expire_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (busy_vec[g] && age_q == AGE_LAST && !hit_vec[g]) |=> !busy_vec[g])
        else $error("expired tag was not freed");
      count_done_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (hit_vec[g] && hits_q + dtit_pkg::TALLY_STEP == expect_cnt) |=> !busy_vec[g])
        else $error("tag kept after its last response");
      count_wait_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        (hit_vec[g] && hits_q + dtit_pkg::TALLY_STEP != expect_cnt && !expired_vec[g])
          |=> busy_vec[g])
        else $error("tag freed before its count was reached");
      owner_load_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        alloc_vec[g] |=> busy_vec[g] && owner_arr[g] == $past(req_in.endpoint_id))
        else $error("allocation did not record the owner");
      owner_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        busy_vec[g] |=> owner_arr[g] == $past(owner_arr[g]))
        else $error("owner changed while the tag was busy");
    end
  endgenerate

  // sticky fault flags; a new event beats a clear in the same cycle
  logic err_evt;
  logic to_evt;
  logic err_flag_q, err_flag_d;
  logic to_flag_q,  to_flag_d;
  logic event_q,    event_d;

  assign err_evt = cpl_fire && cpl_bad;
  assign to_evt  = |expired_vec;

  always_comb begin
    err_flag_d = completion_error_clear_in ? 1'b0 : err_flag_q;
    to_flag_d  = completion_timeout_clear_in ? 1'b0 : to_flag_q;
    if (err_evt) begin
      err_flag_d = 1'b1;
    end
    if (to_evt) begin
      to_flag_d = 1'b1;
    end
    event_d = (err_evt || to_evt) && fault_event_enable_in;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      err_flag_q <= 1'b0;
      to_flag_q  <= 1'b0;
      event_q    <= 1'b0;
    end else begin
      err_flag_q <= err_flag_d;
      to_flag_q  <= to_flag_d;
      event_q    <= event_d;
    end
  end

  assign completion_error_flag_out   = err_flag_q;
  assign completion_timeout_flag_out = to_flag_q;
  assign fault_event_out             = event_q;
  assign tags_busy_out               = busy_vec;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_q);

  logic [dtit_pkg::TAG_W-1:0] last_tag_q, last_tag_d;
  // tag handed out this cycle, kept so the next cycle can name it
  always_comb begin
    last_tag_d = free_tag;
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      last_tag_q <= '0;
    end else begin
      last_tag_q <= last_tag_d;
    end
  end

  tag_unique_a: assert property (
    req_fire |-> !busy_vec[free_tag] ##1 busy_vec[last_tag_q])
    else $error("allocated tag was not free or did not become busy");
  hold_no_tag_a: assert property (
    (&busy_vec) |-> !req_ready_out)
    else $error("request taken with no free tag");
  msg_send_a: assert property (
    req_fire |=> msg_valid_out && msg_out.invalidation_tag == last_tag_q
      && msg_out.endpoint_id == $past(req_in.endpoint_id))
    else $error("message did not follow allocation");
  msg_hold_a: assert property (
    (msg_valid_out && !msg_ready_in) |=> msg_valid_out && $stable(msg_out))
    else $error("message changed while stalled");
  pasid_prefix_a: assert property (
    req_fire |=> msg_out.pasid_prefix == $past(req_in.pasid_valid)
      && (!msg_out.pasid_prefix || msg_out.pasid == $past(req_in.pasid)))
    else $error("prefix does not match request");
  owner_check_a: assert property (
    (cpl_fire && cpl_in.tag_vector != '0 && cpl_bad) |-> hit_vec == '0)
    else $error("bad completion touched a tally");
  err_flag_a: assert property (
    err_evt |=> completion_error_flag_out ##0 (fault_event_out == $past(fault_event_enable_in)))
    else $error("completion error not flagged");
  timeout_flag_a: assert property (
    to_evt |=> completion_timeout_flag_out && (tags_busy_out & $past(expired_vec)) == '0
      && (fault_event_out == $past(fault_event_enable_in)))
    else $error("time-out not flagged");
  done_frees_a: assert property (
    (|done_vec && !req_fire) |=> (busy_vec & $past(done_vec)) == '0)
    else $error("completed tag not freed");

  // allocation order, refusal and release of the message slot
  lowest_tag_a: assert property (
    req_fire |-> ((~busy_vec) & ((NUM_TAGS'(1) << free_tag) - NUM_TAGS'(1))) == '0)
    else $error("a lower free tag was passed over");
  busy_source_a: assert property (
    !req_fire |=> (busy_vec & ~$past(busy_vec)) == '0)
    else $error("tag became busy without a request");
  free_ready_a: assert property (
    (!(&busy_vec) && msg_state_q == dtit_pkg::MSG_IDLE) |-> req_ready_out)
    else $error("request held although a tag was free");
  slot_full_a: assert property (
    (msg_valid_out && !msg_ready_in) |-> !req_ready_out)
    else $error("request taken while the message slot was full");
  msg_release_a: assert property (
    (msg_valid_out && msg_ready_in && !req_fire) |=> !msg_valid_out)
    else $error("message stayed valid after it was taken");
  pasid_zero_a: assert property (
    (msg_valid_out && !msg_out.pasid_prefix) |-> msg_out.pasid == '0)
    else $error("pasid field set without a prefix");
  zero_vector_a: assert property (
    (cpl_fire && cpl_in.tag_vector == '0) |-> !err_evt && hit_vec == '0)
    else $error("empty tag vector was acted on");

  // sticky flags: a new error outranks a clear in the same cycle
  set_wins_a: assert property (
    (err_evt && completion_error_clear_in) |=> completion_error_flag_out)
    else $error("clear overrode a new completion error");
  err_clear_a: assert property (
    (completion_error_clear_in && !err_evt) |=> !completion_error_flag_out)
    else $error("completion error flag did not clear");
  to_clear_a: assert property (
    (completion_timeout_clear_in && !to_evt) |=> !completion_timeout_flag_out)
    else $error("time-out flag did not clear");
  event_mask_a: assert property (
    !fault_event_enable_in |=> !fault_event_out)
    else $error("fault event raised while disabled");
  event_cause_a: assert property (
    !(err_evt || to_evt) |=> !fault_event_out)
    else $error("fault event raised with no cause");
endmodule

/* verification/dtit_ep_model.sv */
// endpoint model answering invalidation messages with completions
`timescale 1ns/1ps
module dtit_ep_model #(
  parameter int DELAY = 4
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    stall_in,
  input  wire logic                    auto_in,
  input  wire logic                    msg_valid_in,
  input  wire dtit_pkg::dtit_inv_msg_t msg_in,
  output logic                         msg_ready_out,
  output logic                         cpl_valid_out,
  output dtit_pkg::dtit_inv_cpl_t      cpl_out
);
  dtit_pkg::dtit_inv_msg_t pend[$];
  int                      wait_q;
  assign msg_ready_out = ~stall_in;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpl_valid_out <= 1'h0;
      cpl_out <= '0;
      wait_q <= 0;
      pend.delete();
    end else begin
      cpl_valid_out <= 1'h0;
      // idle lines toggle so a stale value never looks like a completion
      cpl_out <= dtit_pkg::dtit_inv_cpl_t'(~cpl_out);
      if (msg_valid_in && msg_ready_out && auto_in) begin
        pend.push_back(msg_in);
      end
      if (pend.size() == 0) begin
        wait_q <= 0;
      end else if (wait_q == DELAY) begin
        // delay stands for draining stale traffic before completing
        cpl_valid_out <= 1'h1;
        cpl_out <= '{source_id: pend[0].endpoint_id, completion_count: 3'h1,
                     tag_vector: 32'h1 << pend[0].invalidation_tag};
        void'(pend.pop_front());
        wait_q <= 0;
      end else begin
        wait_q <= wait_q + 1;
      end
    end
  end
endmodule

/* verification/tb.sv */
// self-checking bench for the invalidation tracker
`timescale 1ns/1ps
module tb;
  localparam int TO = 400;
  localparam logic [63:12] ADDR = 52'h0_0012_3456_789A;
  logic ref_clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic req_valid = 1'h0, ev_en = 1'h0, err_clr = 1'h0, to_clr = 1'h0, stall = 1'h0;
  logic auto_on = 1'h0, t_valid = 1'h0;
  logic req_ready, msg_valid, msg_ready, p_valid, cpl_valid, err_flag, to_flag, ev, cpl_ready;
  logic [31:0] busy;
  dtit_pkg::dtit_inv_req_t req = '0;
  dtit_pkg::dtit_inv_msg_t msg, got;
  dtit_pkg::dtit_inv_cpl_t p_cpl, cpl;
  dtit_pkg::dtit_inv_cpl_t t_cpl = '0;
  dtit_pkg::dtit_inv_msg_t msgs[$];
  int n_errors = 0, checks_done = 0, ev_cnt = 0, e;
  always #2.5 ref_clk_in = ~ref_clk_in;
  assign cpl_valid = t_valid | p_valid;
  assign cpl = t_valid ? t_cpl : p_cpl;
  dtit_tracker #(.NUM_TAGS(32), .TIMEOUT_CYCLES(TO)) dtit_tracker_inst (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_in(req), .msg_valid_out(msg_valid),
    .msg_ready_in(msg_ready), .msg_out(msg), .cpl_valid_in(cpl_valid), .cpl_ready_out(cpl_ready),
    .cpl_in(cpl), .fault_event_enable_in(ev_en), .completion_error_clear_in(err_clr),
    .completion_timeout_clear_in(to_clr), .completion_error_flag_out(err_flag),
    .completion_timeout_flag_out(to_flag), .fault_event_out(ev), .tags_busy_out(busy));
  dtit_ep_model dtit_ep_model_inst (
    .clk_in(ref_clk_in), .rst_n_in(resetn_in), .stall_in(stall), .auto_in(auto_on),
    .msg_valid_in(msg_valid), .msg_in(msg), .msg_ready_out(msg_ready),
    .cpl_valid_out(p_valid), .cpl_out(p_cpl));
  always @(posedge ref_clk_in) begin
    if (msg_valid === 1'h1 && msg_ready === 1'h1) msgs.push_back(msg);
    if (ev === 1'h1) ev_cnt++;
  end
  task test_done;
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] x, input string what);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, g, x);
    end
  endtask
  task hang(input string what);
    n_errors++;
    $display("MISMATCH %0t no %s in time", $time, what);
    test_done;
  endtask
  task cycles(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task send_req(input logic [15:0] sid, input logic pv, input logic [19:0] pasid);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    req_valid = 1'h1;
    req = '{endpoint_id: sid, addr: ADDR, size: 1'h0, global_inv: 1'h0,
            pasid_valid: pv, pasid: pasid};
    #1;
    while (req_ready !== 1'h1 && n < 100) begin
      @(negedge ref_clk_in);
      #1;
      n++;
    end
    if (req_ready !== 1'h1) hang("accept");
    @(negedge ref_clk_in);
    req_valid = 1'h0;
  endtask
  task get_msg(input logic [15:0] sid, input logic pv, input logic [19:0] pasid,
               input logic [4:0] tag);
    int n;
    n = 0;
    while (msgs.size() == 0 && n < 100) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (msgs.size() == 0) hang("message");
    got = msgs.pop_front();
    chk(got.endpoint_id, sid, "endpoint");
    chk(got.invalidation_tag, tag, "tag");
    chk(got.addr, ADDR, "addr");
    chk(got.pasid_prefix, pv, "prefix");
    chk(got.pasid, pv ? pasid : 20'h0, "pasid");
  endtask
  task issue(input logic [15:0] sid, input logic pv, input logic [19:0] pasid,
             input logic [4:0] tag);
    send_req(sid, pv, pasid);
    get_msg(sid, pv, pasid, tag);
  endtask
  task send_cpl(input logic [15:0] sid, input logic [31:0] vec, input logic [2:0] cnt);
    @(negedge ref_clk_in);
    t_valid = 1'h1;
    t_cpl = '{source_id: sid, tag_vector: vec, completion_count: cnt};
    @(negedge ref_clk_in);
    t_valid = 1'h0;
    t_cpl = dtit_pkg::dtit_inv_cpl_t'(~t_cpl);
    @(negedge ref_clk_in);
  endtask
  task clear_flags;
    err_clr = 1'h1;
    to_clr = 1'h1;
    @(negedge ref_clk_in);
    err_clr = 1'h0;
    to_clr = 1'h0;
  endtask
  task wait_idle;
    int n;
    n = 0;
    while (busy !== 32'h0 && n < 1000) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (busy !== 32'h0) hang("idle");
    clear_flags;
  endtask
  task sc_basic;
    wait_idle;
    auto_on = 1'h1;
    issue(16'h0100, 1'h1, 20'hABCDE, 5'h00);
    chk(busy[0], 1'h1, "busy after alloc");
    cycles(12);
    chk(busy, 32'h0, "freed by endpoint");
    issue(16'h0200, 1'h0, 20'hFFFFF, 5'h00);
    stall = 1'h1;
    send_req(16'h0201, 1'h0, 20'h0);
    cycles(3);
    chk(msg_valid, 1'h1, "message held");
    chk(req_ready, 1'h0, "ready while blocked");
    stall = 1'h0;
    get_msg(16'h0201, 1'h0, 20'h0, 5'h01);
  endtask
  task sc_error;
    wait_idle;
    auto_on = 1'h0;
    ev_en = 1'h1;
    e = ev_cnt;
    issue(16'h0100, 1'h0, 20'h0, 5'h00);
    send_cpl(16'h0200, 32'h1, 3'h1);
    chk(err_flag, 1'h1, "error flag");
    chk(busy[0], 1'h1, "wrong source dropped");
    chk(ev_cnt - e, 1, "event on error");
    clear_flags;
    chk(err_flag, 1'h0, "error cleared");
    chk(cpl_ready, 1'h1, "completion always taken");
    send_cpl(16'h0100, 32'h0, 3'h1);
    chk({err_flag, busy[0]}, 2'h1, "empty vector ignored");
    send_cpl(16'h0100, 32'h3, 3'h1);
    chk(busy[0], 1'h1, "free tag in vector dropped");
    chk(err_flag, 1'h1, "error on free tag");
    clear_flags;
    ev_en = 1'h0;
    e = ev_cnt;
    send_cpl(16'h0200, 32'h1, 3'h1);
    chk(ev_cnt - e, 0, "event masked");
    @(negedge ref_clk_in);
    t_valid = 1'h1;
    err_clr = 1'h1;
    t_cpl = '{source_id: 16'h0200, tag_vector: 32'h1, completion_count: 3'h1};
    @(negedge ref_clk_in);
    t_valid = 1'h0;
    err_clr = 1'h0;
    cycles(1);
    chk(err_flag, 1'h1, "set beats clear");
    send_cpl(16'h0100, 32'h1, 3'h1);
    chk(busy[0], 1'h0, "right source frees");
  endtask
  task sc_count8;
    wait_idle;
    issue(16'h0300, 1'h0, 20'h0, 5'h00);
    issue(16'h0300, 1'h1, 20'h00011, 5'h01);
    repeat (7) send_cpl(16'h0300, 32'h3, 3'h0);
    chk(busy[1:0], 2'h3, "seven of eight");
    send_cpl(16'h0300, 32'h3, 3'h0);
    chk(busy[1:0], 2'h0, "eighth frees both");
    chk(err_flag, 1'h0, "no error");
    issue(16'h0400, 1'h0, 20'h0, 5'h00);
    send_cpl(16'h0400, 32'h1, 3'h1);
    chk(busy[0], 1'h0, "tally restarts on reuse");
  endtask
  task sc_timeout;
    wait_idle;
    ev_en = 1'h1;
    e = ev_cnt;
    issue(16'h0500, 1'h0, 20'h0, 5'h00);
    cycles(TO - 10);
    chk({busy[0], to_flag}, 2'h2, "before expiry");
    cycles(15);
    chk({busy[0], to_flag}, 2'h1, "after expiry");
    chk(ev_cnt - e, 1, "event on expiry");
    send_cpl(16'h0500, 32'h1, 3'h1);
    chk(err_flag, 1'h1, "late completion");
    clear_flags;
    chk({err_flag, to_flag}, 2'h0, "flags cleared");
  endtask
  task sc_fill;
    wait_idle;
    for (int i = 0; i < 32; i++) issue(16'h0600, 1'h0, 20'h0, i[4:0]);
    chk(busy, 32'hFFFF_FFFF, "all busy");
    chk(req_ready, 1'h0, "no free tag");
    fork
      send_req(16'h0700, 1'h0, 20'h0);
    join_none
    cycles(3);
    chk(msg_valid, 1'h0, "request deferred");
    send_cpl(16'h0600, 32'h20, 3'h1);
    get_msg(16'h0700, 1'h0, 20'h0, 5'h05);
  endtask
  initial begin
    cycles(20);
    resetn_in = 1'h1;
    cycles(3);
    chk(dtit_pkg::TIMEOUT_MS > 50, 1'h1, "timeout margin");
    sc_basic;
    sc_error;
    sc_count8;
    sc_timeout;
    sc_fill;
    test_done;
  end
endmodule
